// File: rtl/eth_offload_pkg.sv
// Constants, types and helpers shared by the checksum offload engines and the MAC-side datapath end.
// Assumes one 25 MHz core clock and one active-low asynchronous reset for both ends.
// Operation
// - Parse Type II, SNAP, up to two VLAN tags
// - Mode 0 sums after byte 14, before FCS
// - Mode 1 sums from first layer-3 byte
// - VLAN tag found by programmable protocol value
// - Third tag identifier acts as type field
// - Checksum appended after frame, before status
// - Status length grows by two when appended
// - Enabled computes every frame, else passes through
// - Software flushes receive path before config changes
// - Receive checksum excludes automatic pad removal
// - Sum 16-bit words, zero-pad odd byte
// - Later byte high, carries added back in
// - Transmit sums on enable, first segment, request
// - Host prepends commands and checksum preamble
// - Transmit sums from start pointer to end
// - Start pointer outside header and last four
// - Result overwrites two bytes at insert location
// - Insert location outside header and last four
// - Request flag clear forwards packet unmodified
// - Checksum inserted inline toward the MAC
// - Preamble: location 27:16, start 11:0
// - Preamble doubleword is never transmitted
// - Transmit inserts ones-complement of sum
// - Zero result inserted unchanged
package eth_offload_pkg;
	// Receive frame parsing.
	localparam logic [11:0] MAC_HDR_BYTES = 12'h00e;
	localparam logic [11:0] TYPE_FIELD_POS = 12'h00c;
	localparam logic [11:0] VLAN_TAG_BYTES = 12'h004;
	localparam logic [11:0] SNAP_HDR_BYTES = 12'h008;
	localparam logic [15:0] MIN_TYPE_VALUE = 16'h0600;
	localparam logic [15:0] VLAN_TPID_RESET = 16'h8100;
	localparam logic [1:0] MAX_VLAN_TAGS = 2'h2;
	// Receive status word length field and the appended checksum size.
	localparam int RX_LEN_LSB = 16;
	localparam int RX_LEN_W = 14;
	localparam logic [13:0] RX_SUM_BYTES = 14'h0002;
	// Transmit command and preamble layout, bytes arrive least significant first.
	localparam logic [11:0] CMD_LAST = 12'h007;
	localparam logic [11:0] PRE_LAST = 12'h003;
	localparam int CMDA_FIRST_SEG_POS = 13;
	localparam int CMDB_OFFLOAD_POS = 46;
	localparam int PRE_INSERT_LSB = 16;
	localparam int PRE_START_LSB = 0;
	localparam int PRE_FIELD_W = 12;
	localparam int TX_BUF_DEPTH = 4096;
	// Register map of the datapath end.
	localparam logic [7:0] OFFLOAD_CTRL_OFS = 8'h00;
	localparam logic [7:0] VLAN_TAG_OFS = 8'h04;
	localparam logic [7:0] MAC_CONTROL_OFS = 8'h08;
	localparam logic [7:0] FRAME_COUNT_OFS = 8'h0c;
	localparam int RX_EN_BIT = 0;
	localparam int RX_MODE_BIT = 1;
	localparam int TX_EN_BIT = 2;
	localparam int PAD_REMOVAL_BIT = 8;
	localparam logic [2:0] OFFLOAD_CTRL_RESET = 3'h0;
	localparam logic [31:0] MAC_CONTROL_RESET = 32'h0000_0000;
	localparam logic [1:0] TX_HOLD_CYCLES = 2'h2;

	typedef enum logic [1:0] {
		RX_PASS = 2'b00,
		RX_SUM_LO = 2'b01,
		RX_SUM_HI = 2'b10,
		RX_STATUS = 2'b11
	} rx_state_e;

	typedef enum logic [2:0] {
		TX_CMD = 3'b000,
		TX_PRE = 3'b001,
		TX_PASS = 3'b010,
		TX_STORE = 3'b011,
		TX_DRAIN = 3'b100
	} tx_state_e;

	// Adds one byte into the running sum at its half, folding the carry back in.
	function automatic logic [15:0] ones_add(input logic [15:0] acc, input logic [7:0] data, input logic high);
		logic [16:0] total;
		total = {1'b0, acc} + (high ? {1'b0, data, 8'h00} : {9'h000, data});
		return total[15:0] + {15'h0000, total[16]};
	endfunction : ones_add
endpackage : eth_offload_pkg

// File: rtl/eth_offload_if.sv
// Interface joining the checksum offload engine to the MAC datapath end.
// Assumes both ends run on the same core clock; signals are plain levels sampled on its rising edge.
`timescale 1ns/1ns
interface eth_offload_if;
	logic rx_checksum_enable;
	logic rx_checksum_mode_select;
	logic tx_checksum_enable;
	logic [15:0] vlan_tag_protocol;
	logic rx_in_valid;
	logic [7:0] rx_in_data;
	logic rx_in_last;
	logic [31:0] rx_in_status;
	logic rx_out_valid;
	logic [7:0] rx_out_data;
	logic rx_out_last;
	logic rx_out_status_valid;
	logic [31:0] rx_out_status;
	logic tx_in_valid;
	logic [7:0] tx_in_data;
	logic tx_in_last;
	logic tx_busy;
	logic tx_out_valid;
	logic [7:0] tx_out_data;
	logic tx_out_last;

	modport engine (
		input rx_checksum_enable, rx_checksum_mode_select, tx_checksum_enable, vlan_tag_protocol,
		input rx_in_valid, rx_in_data, rx_in_last, rx_in_status, tx_in_valid, tx_in_data, tx_in_last,
		output rx_out_valid, rx_out_data, rx_out_last, rx_out_status_valid, rx_out_status,
		output tx_busy, tx_out_valid, tx_out_data, tx_out_last
	);

	modport datapath (
		output rx_checksum_enable, rx_checksum_mode_select, tx_checksum_enable, vlan_tag_protocol,
		output rx_in_valid, rx_in_data, rx_in_last, rx_in_status, tx_in_valid, tx_in_data, tx_in_last,
		input rx_out_valid, rx_out_data, rx_out_last, rx_out_status_valid, rx_out_status,
		input tx_busy, tx_out_valid, tx_out_data, tx_out_last
	);
endinterface : eth_offload_if

// File: rtl/ones_sum_acc.sv
// Running 16-bit end-around-carry sum fed one byte per cycle.
// Assumes the caller says which half of the word each byte belongs to.
`timescale 1ns/1ns
module ones_sum_acc
	import eth_offload_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic add_valid,
	input wire logic [7:0] add_byte,
	input wire logic add_high,
	output logic [15:0] sum
);
	logic [15:0] base;

	// A clear restarts from zero; a byte arriving with it is its first term.
	assign base = clear ? 16'h0000 : sum;

	// An odd trailing byte lands in the low half alone, which is the zero pad.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			sum <= 16'h0000;
		else if (add_valid)
			sum <= ones_add(base, add_byte, add_high);
		else if (clear)
			sum <= 16'h0000;
	end
endmodule : ones_sum_acc

// File: rtl/eth_checksum_offload.sv
// Receive and transmit checksum offload engines between the MAC datapath and the frame FIFOs.
// Assumes the datapath end leaves three idle cycles after each received frame and holds transmit bytes
// while tx_busy is high.
`timescale 1ns/1ns
module eth_checksum_offload
	import eth_offload_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	eth_offload_if.engine link,
	output logic [15:0] last_rx_sum,
	output logic [15:0] last_tx_sum
);
	logic [11:0] rx_idx_reg, rx_start_reg, rx_type_pos_reg, tx_cnt_reg, tx_len_reg, tx_rd_reg, tx_start, tx_loc;
	logic [1:0] rx_tags_reg;
	logic rx_known_reg, rx_append_reg, rx_first, rx_in_sum, rx_in_hi, tx_offload;
	logic [7:0] rx_type_hi_reg, tx_rd_byte;
	logic [7:0] rx_line_reg [0:3];
	logic [3:0] rx_line_sum_reg, rx_line_hi_reg;
	logic [31:0] rx_status_hold_reg, rx_status_next, tx_pre_reg;
	rx_state_e rx_state_reg;
	logic [15:0] rx_sum, rx_type_value, tx_sum, tx_result;
	logic [7:0] tx_buf [0:TX_BUF_DEPTH-1];
	tx_state_e tx_state_reg;
	logic [63:0] tx_cmd_reg;

	// Receive byte position and summing window.
	assign rx_first = rx_idx_reg == 12'h000;
	assign rx_in_sum = link.rx_checksum_enable && rx_known_reg && (rx_idx_reg >= rx_start_reg);
	assign rx_in_hi = rx_idx_reg[0] ^ rx_start_reg[0];
	assign rx_type_value = {rx_type_hi_reg, link.rx_in_data};

	// Position of each received byte within its frame.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			rx_idx_reg <= 12'h000;
		else if (link.rx_in_valid)
			rx_idx_reg <= link.rx_in_last ? 12'h000 : rx_idx_reg + 12'h001;
	end

	// Header parser: finds where summing starts for the selected mode.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_start_reg <= MAC_HDR_BYTES;
			rx_type_pos_reg <= TYPE_FIELD_POS;
			rx_tags_reg <= 2'h0;
			rx_known_reg <= 1'b0;
			rx_type_hi_reg <= 8'h00;
		end
		else if (link.rx_in_valid)
		begin
			if (rx_first)
			begin
				rx_start_reg <= MAC_HDR_BYTES;
				rx_type_pos_reg <= TYPE_FIELD_POS;
				rx_tags_reg <= 2'h0;
				rx_known_reg <= !link.rx_checksum_mode_select;
			end
			else if (!rx_known_reg && rx_idx_reg == rx_type_pos_reg)
				rx_type_hi_reg <= link.rx_in_data;
			else if (!rx_known_reg && rx_idx_reg == rx_type_pos_reg + 12'h001)
			begin
				// A tag beyond the second is not skipped; its identifier is taken as the type.
				if (rx_type_value == link.vlan_tag_protocol && rx_tags_reg < MAX_VLAN_TAGS)
				begin
					rx_tags_reg <= rx_tags_reg + 2'h1;
					rx_type_pos_reg <= rx_type_pos_reg + VLAN_TAG_BYTES;
				end
				else
				begin
					rx_known_reg <= 1'b1;
					if (rx_type_value < MIN_TYPE_VALUE)
						rx_start_reg <= rx_idx_reg + 12'h001 + SNAP_HDR_BYTES;
					else
						rx_start_reg <= rx_idx_reg + 12'h001;
				end
			end
		end
	end

	// Four-byte delay so the trailing FCS is never summed; it is dropped at the frame end.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_line_sum_reg <= 4'h0;
			rx_line_hi_reg <= 4'h0;
			for (int i = 0; i < 4; i++)
				rx_line_reg[i] <= 8'h00;
		end
		else if (link.rx_in_valid)
		begin
			rx_line_reg[0] <= link.rx_in_data;
			for (int i = 1; i < 4; i++)
				rx_line_reg[i] <= rx_line_reg[i-1];
			rx_line_hi_reg <= {rx_line_hi_reg[2:0], rx_in_hi};
			if (link.rx_in_last)
				rx_line_sum_reg <= 4'h0;
			else
				rx_line_sum_reg <= {rx_line_sum_reg[2:0], rx_in_sum};
		end
	end

	ones_sum_acc u_rx_acc (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(link.rx_in_valid && rx_first),
		.add_valid(link.rx_in_valid && rx_line_sum_reg[3]),
		.add_byte(rx_line_reg[3]),
		.add_high(rx_line_hi_reg[3]),
		.sum(rx_sum)
	);

	// Status word with the length widened for the two appended bytes.
	always_comb
	begin
		rx_status_next = rx_status_hold_reg;
		if (rx_append_reg)
			rx_status_next[RX_LEN_LSB +: RX_LEN_W] = rx_status_hold_reg[RX_LEN_LSB +: RX_LEN_W] + RX_SUM_BYTES;
	end

	// Receive output: frame bytes, then the checksum low byte first, then the status word.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_state_reg <= RX_PASS;
			rx_append_reg <= 1'b0;
			rx_status_hold_reg <= 32'h0000_0000;
			link.rx_out_valid <= 1'b0;
			link.rx_out_data <= 8'h00;
			link.rx_out_last <= 1'b0;
			link.rx_out_status_valid <= 1'b0;
			link.rx_out_status <= 32'h0000_0000;
			last_rx_sum <= 16'h0000;
		end
		else
		begin
			link.rx_out_valid <= 1'b0;
			link.rx_out_last <= 1'b0;
			link.rx_out_status_valid <= 1'b0;
			case (rx_state_reg)
				RX_PASS:
				begin
					if (link.rx_in_valid)
					begin
						link.rx_out_valid <= 1'b1;
						link.rx_out_data <= link.rx_in_data;
						link.rx_out_last <= link.rx_in_last && !link.rx_checksum_enable;
						if (link.rx_in_last)
						begin
							rx_status_hold_reg <= link.rx_in_status;
							rx_append_reg <= link.rx_checksum_enable;
							rx_state_reg <= link.rx_checksum_enable ? RX_SUM_LO : RX_STATUS;
						end
					end
				end
				RX_SUM_LO:
				begin
					link.rx_out_valid <= 1'b1;
					link.rx_out_data <= rx_sum[7:0];
					last_rx_sum <= rx_sum;
					rx_state_reg <= RX_SUM_HI;
				end
				RX_SUM_HI:
				begin
					link.rx_out_valid <= 1'b1;
					link.rx_out_data <= rx_sum[15:8];
					link.rx_out_last <= 1'b1;
					rx_state_reg <= RX_STATUS;
				end
				RX_STATUS:
				begin
					link.rx_out_status_valid <= 1'b1;
					link.rx_out_status <= rx_status_next;
					rx_state_reg <= RX_PASS;
				end
				default:
					rx_state_reg <= RX_PASS;
			endcase
		end
	end

	// Transmit preamble fields and the offload decision.
	assign tx_start = tx_pre_reg[PRE_START_LSB +: PRE_FIELD_W];
	assign tx_loc = tx_pre_reg[PRE_INSERT_LSB +: PRE_FIELD_W];
	assign tx_offload = link.tx_checksum_enable && tx_cmd_reg[CMDA_FIRST_SEG_POS] && tx_cmd_reg[CMDB_OFFLOAD_POS];
	assign tx_result = ~tx_sum;

	ones_sum_acc u_tx_acc (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(link.tx_in_valid && tx_state_reg == TX_PRE && tx_cnt_reg == PRE_LAST),
		.add_valid(link.tx_in_valid && tx_state_reg == TX_STORE && tx_cnt_reg >= tx_start),
		.add_byte(link.tx_in_data),
		.add_high(tx_cnt_reg[0] ^ tx_start[0]),
		.sum(tx_sum)
	);

	// Whole offloaded frames are held here, since the result may land before the summed range ends.
	always_ff @(posedge core_clk)
	begin
		if (link.tx_in_valid && tx_state_reg == TX_STORE)
			tx_buf[tx_cnt_reg] <= link.tx_in_data;
	end

	// Replay of the held frame with the result written over two bytes.
	always_comb
	begin
		tx_rd_byte = tx_buf[tx_rd_reg];
		if (tx_rd_reg == tx_loc)
			tx_rd_byte = tx_result[7:0];
		else if (tx_rd_reg == tx_loc + 12'h001)
			tx_rd_byte = tx_result[15:8];
	end

	// Transmit sequencing: commands, optional preamble, then pass-through or store and replay.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_state_reg <= TX_CMD;
			tx_cnt_reg <= 12'h000;
			tx_len_reg <= 12'h000;
			tx_rd_reg <= 12'h000;
			tx_cmd_reg <= 64'h0000_0000_0000_0000;
			tx_pre_reg <= 32'h0000_0000;
			link.tx_busy <= 1'b0;
			link.tx_out_valid <= 1'b0;
			link.tx_out_data <= 8'h00;
			link.tx_out_last <= 1'b0;
			last_tx_sum <= 16'h0000;
		end
		else
		begin
			link.tx_out_valid <= 1'b0;
			link.tx_out_last <= 1'b0;
			case (tx_state_reg)
				TX_CMD:
				begin
					if (link.tx_in_valid)
					begin
						tx_cmd_reg[tx_cnt_reg[2:0]*8 +: 8] <= link.tx_in_data;
						tx_cnt_reg <= (tx_cnt_reg == CMD_LAST) ? 12'h000 : tx_cnt_reg + 12'h001;
						if (tx_cnt_reg == CMD_LAST)
							tx_state_reg <= tx_offload ? TX_PRE : TX_PASS;
					end
				end
				TX_PRE:
				begin
					if (link.tx_in_valid)
					begin
						tx_pre_reg[tx_cnt_reg[1:0]*8 +: 8] <= link.tx_in_data;
						tx_cnt_reg <= (tx_cnt_reg == PRE_LAST) ? 12'h000 : tx_cnt_reg + 12'h001;
						if (tx_cnt_reg == PRE_LAST)
							tx_state_reg <= TX_STORE;
					end
				end
				TX_PASS:
				begin
					if (link.tx_in_valid)
					begin
						link.tx_out_valid <= 1'b1;
						link.tx_out_data <= link.tx_in_data;
						link.tx_out_last <= link.tx_in_last;
						if (link.tx_in_last)
							tx_state_reg <= TX_CMD;
					end
				end
				TX_STORE:
				begin
					if (link.tx_in_valid)
					begin
						tx_cnt_reg <= tx_cnt_reg + 12'h001;
						if (link.tx_in_last)
						begin
							tx_len_reg <= tx_cnt_reg;
							tx_rd_reg <= 12'h000;
							tx_cnt_reg <= 12'h000;
							link.tx_busy <= 1'b1;
							tx_state_reg <= TX_DRAIN;
						end
					end
				end
				TX_DRAIN:
				begin
					link.tx_out_valid <= 1'b1;
					link.tx_out_data <= tx_rd_byte;
					link.tx_out_last <= tx_rd_reg == tx_len_reg;
					tx_rd_reg <= tx_rd_reg + 12'h001;
					if (tx_rd_reg == tx_len_reg)
					begin
						last_tx_sum <= tx_result;
						link.tx_busy <= 1'b0;
						tx_state_reg <= TX_CMD;
					end
				end
				default:
					tx_state_reg <= TX_CMD;
			endcase
		end
	end
endmodule : eth_checksum_offload

// File: rtl/mac_datapath_end.sv
// MAC datapath end: holds the offload configuration behind APB and relays frames to and from the engine.
// Assumes received frames arrive with their FCS and at least three idle cycles between them.
`timescale 1ns/1ns
module mac_datapath_end
	import eth_offload_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	eth_offload_if.datapath link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mac_rx_valid,
	input wire logic [7:0] mac_rx_data,
	input wire logic mac_rx_last,
	input wire logic [31:0] mac_rx_status,
	output logic host_rx_valid,
	output logic [7:0] host_rx_data,
	output logic host_rx_last,
	output logic host_rx_status_valid,
	output logic [31:0] host_rx_status,
	input wire logic host_tx_valid,
	input wire logic [7:0] host_tx_data,
	input wire logic host_tx_last,
	output logic host_tx_ready,
	output logic mac_tx_valid,
	output logic [7:0] mac_tx_data,
	output logic mac_tx_last
);
	logic [2:0] offload_control_reg;
	logic [15:0] vlan_tag_reg;
	logic [31:0] mac_control_reg;
	logic [15:0] rx_frames_reg, tx_frames_reg;
	logic [1:0] tx_hold_reg;
	logic [31:0] rd_data;
	logic rd_hit, tx_take;

	// Register read decode; unmapped words read zero and flag an error.
	always_comb
	begin
		rd_hit = 1'b1;
		rd_data = 32'h0000_0000;
		case (paddr)
			OFFLOAD_CTRL_OFS: rd_data = {29'h0000_0000, offload_control_reg};
			VLAN_TAG_OFS: rd_data = {16'h0000, vlan_tag_reg};
			MAC_CONTROL_OFS: rd_data = mac_control_reg;
			FRAME_COUNT_OFS: rd_data = {tx_frames_reg, rx_frames_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	// APB slave: one wait-free access phase, writes land at its closing edge.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			offload_control_reg <= OFFLOAD_CTRL_RESET;
			vlan_tag_reg <= VLAN_TPID_RESET;
			mac_control_reg <= MAC_CONTROL_RESET;
		end
		else
		begin
			pready <= psel && !penable;
			if (psel && !penable)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= !rd_hit;
			end
			if (psel && penable && pready && pwrite)
			begin
				case (paddr)
					OFFLOAD_CTRL_OFS: offload_control_reg <= pwdata[2:0];
					VLAN_TAG_OFS: vlan_tag_reg <= pwdata[15:0];
					MAC_CONTROL_OFS: mac_control_reg <= pwdata;
					default: ;
				endcase
			end
		end
	end

	// Configuration to the engine; pad removal always wins over the receive checksum.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link.rx_checksum_enable <= 1'b0;
			link.rx_checksum_mode_select <= 1'b0;
			link.tx_checksum_enable <= 1'b0;
			link.vlan_tag_protocol <= VLAN_TPID_RESET;
		end
		else
		begin
			link.rx_checksum_enable <= offload_control_reg[RX_EN_BIT] && !mac_control_reg[PAD_REMOVAL_BIT];
			link.rx_checksum_mode_select <= offload_control_reg[RX_MODE_BIT];
			link.tx_checksum_enable <= offload_control_reg[TX_EN_BIT];
			link.vlan_tag_protocol <= vlan_tag_reg;
		end
	end

	// Receive relay in both directions, counting delivered frames.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link.rx_in_valid <= 1'b0;
			link.rx_in_data <= 8'h00;
			link.rx_in_last <= 1'b0;
			link.rx_in_status <= 32'h0000_0000;
			host_rx_valid <= 1'b0;
			host_rx_data <= 8'h00;
			host_rx_last <= 1'b0;
			host_rx_status_valid <= 1'b0;
			host_rx_status <= 32'h0000_0000;
			rx_frames_reg <= 16'h0000;
		end
		else
		begin
			link.rx_in_valid <= mac_rx_valid;
			link.rx_in_data <= mac_rx_data;
			link.rx_in_last <= mac_rx_valid && mac_rx_last;
			link.rx_in_status <= mac_rx_status;
			host_rx_valid <= link.rx_out_valid;
			host_rx_data <= link.rx_out_data;
			host_rx_last <= link.rx_out_last;
			host_rx_status_valid <= link.rx_out_status_valid;
			host_rx_status <= link.rx_out_status;
			if (link.rx_out_status_valid)
				rx_frames_reg <= rx_frames_reg + 16'h0001;
		end
	end

	assign tx_take = host_tx_valid && host_tx_ready;

	// Transmit relay; ready drops after each frame until the engine has had time to show busy.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link.tx_in_valid <= 1'b0;
			link.tx_in_data <= 8'h00;
			link.tx_in_last <= 1'b0;
			host_tx_ready <= 1'b0;
			tx_hold_reg <= 2'h0;
			mac_tx_valid <= 1'b0;
			mac_tx_data <= 8'h00;
			mac_tx_last <= 1'b0;
			tx_frames_reg <= 16'h0000;
		end
		else
		begin
			link.tx_in_valid <= tx_take;
			link.tx_in_data <= host_tx_data;
			link.tx_in_last <= tx_take && host_tx_last;
			if (tx_take && host_tx_last)
			begin
				tx_hold_reg <= TX_HOLD_CYCLES;
				host_tx_ready <= 1'b0;
			end
			else if (tx_hold_reg != 2'h0)
			begin
				tx_hold_reg <= tx_hold_reg - 2'h1;
				host_tx_ready <= 1'b0;
			end
			else
				host_tx_ready <= !link.tx_busy;
			mac_tx_valid <= link.tx_out_valid;
			mac_tx_data <= link.tx_out_data;
			mac_tx_last <= link.tx_out_last;
			if (link.tx_out_valid && link.tx_out_last)
				tx_frames_reg <= tx_frames_reg + 16'h0001;
		end
	end
endmodule : mac_datapath_end

// File: dv/eth_offload_assertions.sv
// Concurrent checks on the engine side of the offload interface.
// Assumes the bench instantiates it beside the interface, on the shared core clock and reset.
`timescale 1ns/1ns
module eth_offload_assertions
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic rx_checksum_enable,
	input wire logic tx_checksum_enable,
	input wire logic rx_in_valid,
	input wire logic [7:0] rx_in_data,
	input wire logic rx_in_last,
	input wire logic [31:0] rx_in_status,
	input wire logic rx_out_valid,
	input wire logic [7:0] rx_out_data,
	input wire logic rx_out_last,
	input wire logic rx_out_status_valid,
	input wire logic [31:0] rx_out_status,
	input wire logic tx_busy,
	input wire logic tx_out_valid,
	input wire logic tx_out_last
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// An enabled frame end yields two sum bytes, the last flag on the second, then the status.
	sequence s_end;
		rx_checksum_enable && rx_in_valid && rx_in_last;
	endsequence
	sequence s_tail;
		rx_out_valid && !rx_out_last ##1 rx_out_valid && !rx_out_last ##1 rx_out_valid && rx_out_last ##1 rx_out_status_valid;
	endsequence
	property p_rx_copy; rx_in_valid |=> rx_out_valid && rx_out_data == $past(rx_in_data); endproperty
	property p_rx_tail; s_end |=> s_tail; endproperty
	property p_rx_len; s_end |=> ##3 rx_out_status[29:16] == $past(rx_in_status[29:16], 4) + 14'h0002; endproperty
	property p_rx_plain;
		!rx_checksum_enable && rx_in_valid && rx_in_last |=> rx_out_last ##1 rx_out_status_valid && rx_out_status == $past(rx_in_status, 2);
	endproperty
	property p_rx_extra; rx_out_valid && !$past(rx_in_valid) |-> rx_checksum_enable; endproperty
	property p_rx_stat; rx_out_status_valid |-> $past(rx_out_last); endproperty
	property p_tx_rose; $rose(tx_busy) |-> tx_checksum_enable; endproperty
	property p_tx_idle; !tx_checksum_enable |-> !tx_busy; endproperty
	property p_tx_last; tx_out_last |-> tx_out_valid && !tx_busy; endproperty
	a_rx_copy: assert property (p_rx_copy) else $error("receive byte not copied");
	a_rx_tail: assert property (p_rx_tail) else $error("sum bytes not appended");
	a_rx_len: assert property (p_rx_len) else $error("status length not grown by two");
	a_rx_plain: assert property (p_rx_plain) else $error("disabled frame altered");
	a_rx_extra: assert property (p_rx_extra) else $error("extra byte while disabled");
	a_rx_stat: assert property (p_rx_stat) else $error("status not after last byte");
	a_tx_rose: assert property (p_tx_rose) else $error("store without enable");
	a_tx_idle: assert property (p_tx_idle) else $error("busy while disabled");
	a_tx_last: assert property (p_tx_last) else $error("last without valid or busy not released");
endmodule : eth_offload_assertions

// File: dv/tb.sv
// Self-checking bench joining both offload ends through the interface.
// Assumes the package constants and a 25 MHz core clock.
`timescale 1ns/1ns
module tb
	import eth_offload_pkg::*;
;
	logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, er, rx_done;
	logic mac_rx_valid, mac_rx_last, host_rx_valid, host_rx_last, host_rx_status_valid;
	logic host_tx_valid, host_tx_last, host_tx_ready, mac_tx_valid, mac_tx_last;
	logic [7:0] paddr, mac_rx_data, host_rx_data, host_tx_data, mac_tx_data;
	logic [31:0] pwdata, prdata, mac_rx_status, host_rx_status, rd, rx_st;
	logic [7:0] rxq[$], txq[$], f[$], pkt[$], ex[$];
	int err_count, num_checks, cyc;
	eth_offload_if lk();
	eth_checksum_offload eth_checksum_offload_i (.core_clk, .reset_n, .link(lk), .last_rx_sum(), .last_tx_sum());
	mac_datapath_end mac_datapath_end_i (.core_clk, .reset_n, .link(lk), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .mac_rx_valid, .mac_rx_data, .mac_rx_last, .mac_rx_status, .host_rx_valid,
		.host_rx_data, .host_rx_last, .host_rx_status_valid, .host_rx_status, .host_tx_valid, .host_tx_data,
		.host_tx_last, .host_tx_ready, .mac_tx_valid, .mac_tx_data, .mac_tx_last);
	eth_offload_assertions eth_offload_assertions_i (.core_clk, .reset_n, .rx_checksum_enable(lk.rx_checksum_enable),
		.tx_checksum_enable(lk.tx_checksum_enable), .rx_in_valid(lk.rx_in_valid), .rx_in_data(lk.rx_in_data),
		.rx_in_last(lk.rx_in_last), .rx_in_status(lk.rx_in_status), .rx_out_valid(lk.rx_out_valid),
		.rx_out_data(lk.rx_out_data), .rx_out_last(lk.rx_out_last), .rx_out_status_valid(lk.rx_out_status_valid),
		.rx_out_status(lk.rx_out_status), .tx_busy(lk.tx_busy), .tx_out_valid(lk.tx_out_valid),
		.tx_out_last(lk.tx_out_last));
	// Free-running core clock.
	initial
	begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	// Collects host and MAC side output, and cuts a hang short.
	always @(posedge core_clk)
	begin
		if (host_rx_valid === 1'b1) rxq.push_back(host_rx_data);
		if (host_rx_status_valid === 1'b1) begin rx_st = host_rx_status; rx_done = 1; end
		if (mac_tx_valid === 1'b1) txq.push_back(mac_tx_data);
		cyc++;
		if (cyc == 5000) begin err_count++; report_and_stop(); end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin $display("Error %s expected %h seen %h", n, e, g); err_count++; end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// End-around-carry sum, earlier byte low, odd tail padded by zero.
	function automatic logic [15:0] csum(input logic [7:0] q[$], input int s, input int e);
		logic [16:0] t;
		csum = 16'h0000;
		for (int i = s; i < e; i++)
		begin
			t = {1'b0, csum} + (((i - s) % 2) ? {1'b0, q[i], 8'h00} : {9'h000, q[i]});
			csum = t[15:0] + {15'h0000, t[16]};
		end
	endfunction : csum
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata; er = pslverr; psel <= 0; penable <= 0;
		@(posedge core_clk);
	endtask : apb
	task automatic rx_run(input int s, input logic on);
		logic [15:0] sm;
		sm = csum(f, s, f.size() - 4);
		rxq = {}; rx_done = 0;
		foreach (f[i])
		begin
			mac_rx_valid <= 1;
			mac_rx_data <= f[i];
			mac_rx_last <= (i == f.size() - 1);
			mac_rx_status <= 32'(f.size()) << 16;
			@(posedge core_clk);
		end
		mac_rx_valid <= 0; mac_rx_last <= 0;
		repeat (14) @(posedge core_clk);
		ex = f;
		if (on) begin ex.push_back(sm[7:0]); ex.push_back(sm[15:8]); end
		chk("rx status seen", 32'h1, {31'h0, rx_done});
		chk("rx byte count", 32'(ex.size()), 32'(rxq.size()));
		foreach (ex[i]) chk("rx byte", {24'h0, ex[i]}, {24'h0, rxq[i]});
		chk("rx status length", 32'(ex.size()), {18'h0, rx_st[29:16]});
	endtask : rx_run
	task automatic tx_run(input logic [7:0] bflag, input logic on);
		logic [15:0] sm;
		sm = ~csum(f, 14, f.size());
		pkt = {8'h00, 8'h20, 8'h00, 8'h00, 8'h00, bflag, 8'h00, 8'h00};
		if (on) pkt = {pkt, 8'h0e, 8'h00, 8'h10, 8'h00, f}; else pkt = {pkt, f};
		ex = f;
		if (on) begin ex[16] = sm[7:0]; ex[17] = sm[15:8]; end
		txq = {};
		foreach (pkt[i])
		begin
			host_tx_valid <= 1;
			host_tx_data <= pkt[i];
			host_tx_last <= (i == pkt.size() - 1);
			do @(posedge core_clk); while (host_tx_ready !== 1'b1);
		end
		host_tx_valid <= 0; host_tx_last <= 0;
		repeat (60) @(posedge core_clk);
		chk("tx byte count", 32'(ex.size()), 32'(txq.size()));
		foreach (ex[i]) chk("tx byte", {24'h0, ex[i]}, {24'h0, txq[i]});
	endtask : tx_run
	task automatic t_regs();
		apb(0, OFFLOAD_CTRL_OFS, 0); chk("control reset", 32'h0, rd);
		apb(0, VLAN_TAG_OFS, 0); chk("tag reset", 32'h8100, rd);
		apb(0, 8'h40, 0); chk("unmapped error", 32'h1, {31'h0, er});
	endtask : t_regs
	task automatic t_rx();
		rx_run(14, 0);
		apb(1, OFFLOAD_CTRL_OFS, 32'h1); rx_run(14, 1);
		apb(1, OFFLOAD_CTRL_OFS, 32'h3); rx_run(18, 1);
		apb(1, VLAN_TAG_OFS, 32'h9100); rx_run(14, 1);
		apb(1, VLAN_TAG_OFS, 32'h8100);
		apb(1, MAC_CONTROL_OFS, 32'h100);
		rx_run(14, 0);
	endtask : t_rx
	task automatic t_tx();
		apb(1, OFFLOAD_CTRL_OFS, 32'h4);
		tx_run(8'h40, 1);
		tx_run(8'h00, 0);
		apb(0, FRAME_COUNT_OFS, 0);
		chk("frame counts", 32'h0002_0005, rd);
	endtask : t_tx
	// Drives every input idle, resets, builds a tagged odd-length frame, then runs the scenarios.
	initial
	begin
		reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		mac_rx_valid = 0; mac_rx_data = 0; mac_rx_last = 0; mac_rx_status = 0;
		host_tx_valid = 0; host_tx_data = 0; host_tx_last = 0;
		for (int i = 0; i < 27; i++) f.push_back(8'(i * 37 + 5));
		f[12] = 8'h81; f[13] = 8'h00; f[16] = 8'h08; f[17] = 8'h00;
		repeat (12) @(posedge core_clk);
		reset_n <= 1;
		@(posedge core_clk);
		t_regs();
		t_rx();
		t_tx();
		report_and_stop();
	end
endmodule : tb
